/* File: logic/reset_source_combiner.sv */
// Reset source combiner: merges all reset sources into one active-low master reset,
// records causes, sequences power-up and oscillator delays, and releases the core.
// Assumes detector, pin and oscillator inputs are asynchronous and are synchronised here.
//
// Function
// - Any active reset source asserts master reset.
// - Each reset kind sets its own flag.
// - Power-on clears flags except power-on flag.
// - Software writes flags freely, never causing reset.
// - Bit 15 flags trap conflict reset.
// - Bit 14 flags illegal condition reset.
// - Bit 8 keeps regulator active in sleep.
// - Bit 7 pin reset, bit 6 instruction.
// - Bit 5 enables watchdog; fuse overrides.
// - Bits 4,3,2: watchdog, sleep, idle.
// - Bits 1,0 brown-out, power-on; reset to one.
// - Cold reset selects clock from fuse bits.
// - Warm reset keeps current clock selection.
// - Hold reset until power-on delay elapsed.
// - Hold reset until brown-out delay elapsed.
// - Power-up timer holds, then oscillator enabled.
// - Clock-ready delay depends on oscillator mode.
// - Start-up timer counts 1024 oscillator periods.
// - PLL adds 1.5 ms lock time.
// - RC start-up 1.1 us or 70 us.
// - Execution starts at address zero.
// - Clock monitor starts after its delay.
// - Instruction reset keeps clock, two cycles.
// - Watchdog in sleep or idle wakes instead.
`timescale 1ns/1ps
module reset_source_combiner #(
	parameter int POR_DELAY_CYC  = 5000,   // Power-on settle delay in cycles.
	parameter int BOR_DELAY_CYC  = 5000,   // Brown-out settle delay in cycles.
	parameter int POWERUP_TIMER_UNIT_CYC  = 100000, // One millisecond of power-up timer in cycles.
	parameter int LOCK_DELAY_CYC = rst_comb_pkg::LOCK_CYC, // PLL lock wait in cycles.
	parameter int MON_DELAY_CYC  = 100     // Clock monitor start delay in cycles.
) (
	// Clock and synchronous reset.
	input  wire logic                              core_clk_i,
	input  wire logic                              rst_b_i,
	// Analog detectors and external pin, asynchronous.
	input  wire logic                              por_active_i,
	input  wire logic                              bor_active_i,
	input  wire logic                              ext_reset_pin_n_i,
	// Core events, same clock domain.
	input  wire logic                              sw_reset_i,
	input  wire logic                              wdog_timeout_i,
	input  wire logic                              trap_conflict_i,
	input  wire logic                              illegal_cond_i,
	input  wire logic                              enter_sleep_i,
	input  wire logic                              enter_idle_i,
	// Configuration fuses and oscillator state.
	input  wire logic                              wdog_fuse_enable_i,
	input  wire logic [2:0]                        initial_osc_select_i,
	input  wire logic [2:0]                        powerup_delay_sel_i,
	input  wire logic                              clock_fail_monitor_en_i,
	input  wire logic                              osc_tick_i,
	// Register port.
	input  wire logic [3:0]                        reg_addr_i,
	input  wire logic [15:0]                       reg_wdata_i,
	input  wire logic                              reg_wr_i,
	input  wire logic                              reg_rd_i,
	output logic [15:0]                            reg_rdata_o,
	// Outputs to core and clock system.
	output logic                                   master_reset_n_o,
	output logic [2:0]                             current_osc_select_o,
	output logic                                   osc_enable_o,
	output logic                                   clock_ready_o,
	output logic [23:0]                            fetch_addr_o,
	output logic                                   monitor_active_o,
	output logic                                   wdog_enable_o,
	output logic                                   regulator_sleep_keep_o,
	output logic                                   wdog_wake_o
);
	import rst_comb_pkg::*;

	// Sequencer states, one-hot.
	typedef enum logic [5:0] {
		ST_POWER = 6'h01, // Waiting for supply detectors and their delays.
		ST_POWERUP_TIMER  = 6'h02, // Power-up timer running.
		ST_OSCD  = 6'h04, // Oscillator start-up delay.
		ST_OST   = 6'h08, // Oscillator start-up timer.
		ST_LOCK  = 6'h10, // PLL lock wait.
		ST_RUN   = 6'h20  // Clock ready, core running.
	} seq_state_t;

	seq_state_t        state_r;       // Sequencer state.
	logic [CNT_W-1:0]  cnt_r;         // Shared delay counter.
	logic [10:0]       ost_r;         // Oscillator period counter.
	logic [1:0]        por_sync_r;    // Power-on detector synchroniser.
	logic [1:0]        bor_sync_r;    // Brown-out detector synchroniser.
	logic [1:0]        pin_sync_r;    // Pin synchroniser, active low.
	logic [1:0]        tick_sync_r;   // Oscillator tick synchroniser.
	logic              tick_d_r;      // Previous tick for edge detect.
	logic [15:0]       cause_r;       // Reset cause register.
	logic              cold_r;        // Current hold stems from power-on or brown-out.
	logic              warm_hold_r;   // Warm reset hold request.
	logic [CNT_W-1:0]  mon_cnt_r;     // Clock monitor start counter.
	logic              asleep_r;      // Core is in sleep or idle.

	// Synchronised views of asynchronous inputs.
	logic por_s, bor_s, pin_s, tick_edge, low_power, wdog_reset, warm_evt, cold_evt;
	assign por_s      = por_sync_r[1];
	assign bor_s      = bor_sync_r[1];
	assign pin_s      = ~pin_sync_r[1];
	assign tick_edge  = tick_sync_r[1] & ~tick_d_r;
	assign low_power  = asleep_r;
	// A watchdog timeout in sleep or idle wakes rather than resets.
	assign wdog_reset = wdog_timeout_i & ~low_power;
	assign warm_evt   = pin_s | sw_reset_i | wdog_reset | trap_conflict_i | illegal_cond_i;
	assign cold_evt   = por_s | bor_s;

	// Two-flop synchronisers for detectors, pin and oscillator ticks.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			por_sync_r  <= 2'h3;
			bor_sync_r  <= 2'h0;
			pin_sync_r  <= 2'h3;
			tick_sync_r <= 2'h0;
			tick_d_r    <= 1'b0;
		end else begin
			por_sync_r  <= {por_sync_r[0], por_active_i};
			bor_sync_r  <= {bor_sync_r[0], bor_active_i};
			pin_sync_r  <= {pin_sync_r[0], ext_reset_pin_n_i};
			tick_sync_r <= {tick_sync_r[0], osc_tick_i};
			tick_d_r    <= tick_sync_r[1];
		end
	end

	// Track sleep and idle so a watchdog timeout can be turned into a wake-up.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			asleep_r    <= 1'b0;
			wdog_wake_o <= 1'b0;
		end else begin
			wdog_wake_o <= wdog_timeout_i & asleep_r;
			if (enter_sleep_i || enter_idle_i) begin
				asleep_r <= 1'b1;
			end else if (wdog_timeout_i || !master_reset_n_o) begin
				asleep_r <= 1'b0;
			end
		end
	end

	// Delay of the power-up timer: 0 ms, then 2^(sel-1) ms up to 64 ms.
	function automatic logic [CNT_W-1:0] powerup_timer_cycles(input logic [2:0] sel);
		logic [31:0] ms;
		ms = (sel == 3'h0) ? 32'h0 : (32'h1 << (sel + 3'h0));
		if (sel == 3'h0) begin
			powerup_timer_cycles = '0;
		end else begin
			powerup_timer_cycles = CNT_W'(ms * POWERUP_TIMER_UNIT_CYC / 2);
		end
	endfunction

	// PLL and crystal membership of an oscillator mode.
	function automatic logic mode_pll(input logic [2:0] m);
		mode_pll = (m == OSC_FRCPLL) || (m == OSC_XTPLL) || (m == OSC_HSPLL);
	endfunction
	function automatic logic mode_xtal(input logic [2:0] m);
		mode_xtal = (m == OSC_XT) || (m == OSC_HS) || (m == OSC_XTPLL) || (m == OSC_HSPLL);
	endfunction

	// Reset sequencer: detectors, power-up timer, oscillator delays, then run.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			state_r <= ST_POWER;
			cnt_r   <= '0;
			ost_r   <= '0;
			cold_r  <= 1'b1;
		end else if (cold_evt) begin
			// Detectors active: restart the whole hold.
			state_r <= ST_POWER;
			cnt_r   <= '0;
			ost_r   <= '0;
			cold_r  <= 1'b1;
		end else begin
			case (state_r)
				ST_POWER: begin
					// Hold until the supply settle delay has elapsed.
					if (cnt_r >= CNT_W'(cold_r && cause_r[BIT_BOR] ? BOR_DELAY_CYC : POR_DELAY_CYC)) begin
						state_r <= ST_POWERUP_TIMER;
						cnt_r   <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_POWERUP_TIMER: begin
					if (cnt_r >= powerup_timer_cycles(powerup_delay_sel_i)) begin
						cnt_r   <= '0;
						state_r <= (current_osc_select_o == OSC_EC) ? ST_RUN : ST_OSCD;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_OSCD: begin
					// RC start-up bound, by oscillator family.
					if (cnt_r >= CNT_W'(current_osc_select_o == OSC_LOW_POWER_RC_OSC ? LOW_POWER_RC_OSC_CYC : FRC_CYC)) begin
						cnt_r   <= '0;
						state_r <= mode_xtal(current_osc_select_o) ? ST_OST :
						           mode_pll(current_osc_select_o) ? ST_LOCK : ST_RUN;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_OST: begin
					// Count oscillator periods, not core cycles.
					if (ost_r == 11'(OST_PERIODS)) begin
						state_r <= mode_pll(current_osc_select_o) ? ST_LOCK : ST_RUN;
					end else if (tick_edge) begin
						ost_r <= ost_r + 1'b1;
					end
				end
				ST_LOCK: begin
					if (cnt_r >= CNT_W'(LOCK_DELAY_CYC)) begin
						state_r <= ST_RUN;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_RUN: begin
					cold_r <= 1'b0;
				end
				default: begin
					state_r <= ST_POWER;
				end
			endcase
		end
	end

	// Warm sources hold master reset for one cycle beyond the event; clock untouched.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			warm_hold_r <= 1'b0;
		end else begin
			warm_hold_r <= warm_evt;
		end
	end

	// Master reset, registered so its release is a clean clock edge.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			master_reset_n_o <= 1'b0;
		end else begin
			master_reset_n_o <= ~(cold_evt || warm_evt || warm_hold_r || state_r != ST_RUN);
		end
	end

	// Clock selection: fuses on cold reset, current source kept on warm reset.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			current_osc_select_o <= OSC_FRC;
			osc_enable_o         <= 1'b0;
			clock_ready_o        <= 1'b0;
			fetch_addr_o         <= RESET_VECTOR;
		end else begin
			if (state_r == ST_POWER) begin
				current_osc_select_o <= initial_osc_select_i;
			end
			// Warm resets leave the selection alone.
			osc_enable_o  <= (state_r != ST_POWER) && (state_r != ST_POWERUP_TIMER);
			clock_ready_o <= (state_r == ST_RUN);
			fetch_addr_o  <= RESET_VECTOR;
		end
	end

	// Clock monitor starts after clock ready plus its own delay.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			mon_cnt_r        <= '0;
			monitor_active_o <= 1'b0;
		end else if (state_r != ST_RUN || !clock_fail_monitor_en_i) begin
			mon_cnt_r        <= '0;
			monitor_active_o <= 1'b0;
		end else if (mon_cnt_r >= CNT_W'(MON_DELAY_CYC)) begin
			monitor_active_o <= 1'b1;
		end else begin
			mon_cnt_r <= mon_cnt_r + 1'b1;
		end
	end

	// Cause register: events set flags, software writes; an event wins over a write.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			cause_r <= CAUSE_RESET;
		end else begin
			logic [15:0] nxt;
			nxt = cause_r;
			if (reg_wr_i && reg_addr_i == ADDR_CAUSE) begin
				// Writes only store and never cause a reset; the stored brown-out flag picks the settle delay.
				nxt = reg_wdata_i & CAUSE_MASK;
			end
			if (por_s) begin
				nxt = (nxt & ((16'h1 << BIT_SWDEN) | (16'h1 << BIT_VREG))) | (16'h1 << BIT_POR);
			end else if (bor_s) begin
				nxt[BIT_BOR]   = 1'b1;
				nxt[BIT_TRAP]  = 1'b0;
				nxt[BIT_ILL]   = 1'b0;
				nxt[BIT_SWR]   = 1'b0;
				nxt[BIT_WDOG_TIMEOUT_FLAG]  = 1'b0;
				nxt[BIT_SLEEP] = 1'b0;
				nxt[BIT_IDLE]  = 1'b0;
			end
			if (trap_conflict_i) nxt[BIT_TRAP] = 1'b1;
			if (illegal_cond_i)  nxt[BIT_ILL]  = 1'b1;
			if (pin_s)           nxt[BIT_EXT]  = 1'b1;
			if (sw_reset_i)      nxt[BIT_SWR]  = 1'b1;
			if (wdog_timeout_i)  nxt[BIT_WDOG_TIMEOUT_FLAG] = 1'b1;
			if (enter_sleep_i)   nxt[BIT_SLEEP] = 1'b1;
			if (enter_idle_i)    nxt[BIT_IDLE] = 1'b1;
			cause_r <= nxt;
		end
	end

	// Control bits to the watchdog and regulator.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			wdog_enable_o          <= 1'b0;
			regulator_sleep_keep_o <= 1'b0;
		end else begin
			wdog_enable_o          <= wdog_fuse_enable_i | cause_r[BIT_SWDEN];
			regulator_sleep_keep_o <= cause_r[BIT_VREG];
		end
	end

	// Read data, valid the cycle after the read strobe; unmapped reads give zero.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_CAUSE: reg_rdata_o <= cause_r & CAUSE_MASK;
				ADDR_STAT:  reg_rdata_o <= {8'h00, cold_r, monitor_active_o, state_r};
				default:    reg_rdata_o <= 16'h0000;
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end
endmodule

/* File: logic/rst_comb_pkg.sv */
// Constants for the reset source combiner: register map, field positions, reset values and delays.
// Assumes a 100 MHz core clock; analog detectors and oscillators sit outside this logic.
package rst_comb_pkg;
	// Register map of the plain register port (word addresses).
	localparam logic [3:0] ADDR_CAUSE = 4'h0; // Reset cause and control register.
	localparam logic [3:0] ADDR_STAT  = 4'h1; // Sequencer status register.
	// Field positions in the reset cause register.
	localparam int BIT_POR   = 0;
	localparam int BIT_BOR   = 1;
	localparam int BIT_IDLE  = 2;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_WDOG_TIMEOUT_FLAG  = 4;
	localparam int BIT_SWDEN = 5;
	localparam int BIT_SWR   = 6;
	localparam int BIT_EXT   = 7;
	localparam int BIT_VREG  = 8;
	localparam int BIT_ILL   = 14;
	localparam int BIT_TRAP  = 15;
	// Implemented bits; bits 13..9 are absent.
	localparam logic [15:0] CAUSE_MASK  = 16'hC1FF;
	// Value loaded by the synchronous reset: only the power-on and brown-out flags set.
	localparam logic [15:0] CAUSE_RESET = 16'h0003;
	// Reset vector driven to the core.
	localparam logic [23:0] RESET_VECTOR = 24'h000000;
	// Oscillator mode codes.
	localparam logic [2:0] OSC_FRC   = 3'h0;
	localparam logic [2:0] OSC_FRCPLL = 3'h1;
	localparam logic [2:0] OSC_XT    = 3'h2;
	localparam logic [2:0] OSC_HS    = 3'h3;
	localparam logic [2:0] OSC_EC    = 3'h4;
	localparam logic [2:0] OSC_XTPLL = 3'h5;
	localparam logic [2:0] OSC_HSPLL = 3'h6;
	localparam logic [2:0] OSC_LOW_POWER_RC_OSC  = 3'h7;
	// Timing: core clock and documented delays.
	localparam int CLK_MHZ        = 100;
	localparam int FRC_DELAY_NS   = 1100;  // 1.1 us.
	localparam int LOW_POWER_RC_OSC_DELAY_NS  = 70000; // 70 us.
	localparam int LOCK_TIME_US   = 1500;  // 1.5 ms.
	localparam int OST_PERIODS    = 1024;  // Oscillator periods for the start-up timer.
	// Longest times round down, never below one cycle.
	localparam int FRC_CYC  = (FRC_DELAY_NS * CLK_MHZ / 1000 < 1) ? 1 : FRC_DELAY_NS * CLK_MHZ / 1000;
	localparam int LOW_POWER_RC_OSC_CYC = (LOW_POWER_RC_OSC_DELAY_NS * CLK_MHZ / 1000 < 1) ? 1 : LOW_POWER_RC_OSC_DELAY_NS * CLK_MHZ / 1000;
	localparam int LOCK_CYC = LOCK_TIME_US * CLK_MHZ;
	localparam int CNT_W    = 24;
endpackage

/* File: tb/core_model.sv */
// Behavioural processor core: turns bench commands into the core's one-cycle event pulses.
// Assumes the bench drives the command at a clock edge for exactly one cycle.
`timescale 1ns/1ps
module core_model (
	// Master reset that the core obeys.
	input  wire logic       master_reset_n_i,
	// Command from the bench.
	input  wire logic       go_i,
	input  wire logic [2:0] cmd_i,
	// Event pulses towards the reset block.
	output logic            sw_reset_o,
	output logic            trap_conflict_o,
	output logic            illegal_cond_o,
	output logic            wdog_timeout_o,
	output logic            enter_sleep_o,
	output logic            enter_idle_o
);
	// A halted core executes nothing, so a command given during reset is lost.
	logic run;
	assign run             = go_i && master_reset_n_i;
	assign sw_reset_o      = run && cmd_i == 3'h0;
	assign trap_conflict_o = run && cmd_i == 3'h1;
	assign illegal_cond_o  = run && cmd_i == 3'h2;
	assign wdog_timeout_o  = run && cmd_i == 3'h3;
	assign enter_sleep_o   = run && cmd_i == 3'h4;
	assign enter_idle_o    = run && cmd_i == 3'h5;
endmodule

/* File: tb/reset_source_combiner_chk.sv */
// Checker for the reset source combiner: timing of master reset, register port and start-up outputs.
// Assumes it is bound to the top module and sees only its ports, all in the core clock domain.
`timescale 1ns/1ps
module reset_source_combiner_chk
	import rst_comb_pkg::*;
#(
	parameter int MON_DELAY_CYC = 100 // Clock monitor start delay in cycles.
) (
	// Clock, reset and the inputs that cause events.
	input wire logic        core_clk_i,
	input wire logic        rst_b_i,
	input wire logic        sw_reset_i,
	input wire logic        trap_conflict_i,
	input wire logic        illegal_cond_i,
	input wire logic        wdog_fuse_enable_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	// Outputs under watch.
	input wire logic [15:0] reg_rdata_o,
	input wire logic        master_reset_n_o,
	input wire logic [2:0]  current_osc_select_o,
	input wire logic        osc_enable_o,
	input wire logic        clock_ready_o,
	input wire logic [23:0] fetch_addr_o,
	input wire logic        monitor_active_o,
	input wire logic        wdog_enable_o,
	input wire logic        regulator_sleep_keep_o,
	input wire logic        wdog_wake_o
);
	// One clock domain, so clock and disable are given once for all properties.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_vector_zero: assert property (fetch_addr_o == RESET_VECTOR)
		else $error("fetch address is not the reset vector");
	a_source_resets: assert property ((trap_conflict_i || illegal_cond_i) && master_reset_n_o |=> !master_reset_n_o)
		else $error("event did not assert master reset");
	a_sw_reset_brief: assert property (sw_reset_i && master_reset_n_o |=> !master_reset_n_o [*2] ##1 master_reset_n_o)
		else $error("instruction reset not held exactly two cycles");
	a_warm_keeps_osc: assert property (sw_reset_i && master_reset_n_o |=> $stable(current_osc_select_o) [*3])
		else $error("warm reset changed the oscillator selection");
	a_wake_no_reset: assert property (wdog_wake_o |-> master_reset_n_o ##1 master_reset_n_o)
		else $error("wake from sleep also reset the core");
	a_release_ready: assert property ($rose(master_reset_n_o) |-> clock_ready_o && osc_enable_o)
		else $error("master reset released before the clock was ready");
	a_monitor_late: assert property ($rose(monitor_active_o) |-> $past(clock_ready_o, MON_DELAY_CYC))
		else $error("clock monitor started before its delay");
	a_fuse_wdog: assert property (master_reset_n_o && $past(master_reset_n_o) && $past(wdog_fuse_enable_i) |-> wdog_enable_o)
		else $error("fuse did not force the watchdog on");
	a_keep_follows: assert property (reg_wr_i && reg_addr_i == ADDR_CAUSE && reg_wdata_i[8] |-> ##[1:2] regulator_sleep_keep_o)
		else $error("regulator keep output did not follow the write");
	a_rsvd_zero: assert property (reg_rd_i |=> reg_rdata_o[13:9] == 5'h00)
		else $error("absent cause bits read non-zero");
	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data present without a read");

	// Main scenarios reached by the bench.
	c_release: cover property ($rose(master_reset_n_o));
	c_wake: cover property (wdog_wake_o);
	c_monitor: cover property ($rose(monitor_active_o));
endmodule

bind reset_source_combiner reset_source_combiner_chk #(.MON_DELAY_CYC(MON_DELAY_CYC)) chk_inst (
	.core_clk_i, .rst_b_i, .sw_reset_i, .trap_conflict_i, .illegal_cond_i, .wdog_fuse_enable_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .master_reset_n_o, .current_osc_select_o, .osc_enable_o,
	.clock_ready_o, .fetch_addr_o, .monitor_active_o, .wdog_enable_o, .regulator_sleep_keep_o, .wdog_wake_o);

/* File: tb/tb_reset_source_combiner.sv */
// Self-checking bench for the reset source combiner against an integer model of the cause register.
// Assumes short delay parameters so cold start-up takes under 150 cycles.
`timescale 1ns/1ps
module tb_reset_source_combiner;
	import rst_comb_pkg::*;
	logic        clk, rst_b, por, bor, pin_n, fuse, tick, go, wr, rd;
	logic [2:0]  osc_sel, cmd, cur_osc, pdsel; // Fuse oscillator code, core command, selection, power-up select.
	logic        mon_en;                      // Clock monitor enable fuse.
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, d;
	logic [23:0] fetch;
	logic        mrst_n, osc_en, ready, mon, wden, keep, wake, sw, trap, ill, wdt, slp, idl;
	int          failures = 0, tests_run = 0, cyc = 0, wakes = 0, exp, n;
	int          bits[4] = '{6, 15, 14, 4}; // Flag raised by each core reset event, commands 0 to 3.

	reset_source_combiner #(.POR_DELAY_CYC(10), .BOR_DELAY_CYC(10), .POWERUP_TIMER_UNIT_CYC(10), .LOCK_DELAY_CYC(20),
		.MON_DELAY_CYC(5)) reset_source_combiner_inst (
		.core_clk_i(clk), .rst_b_i(rst_b), .por_active_i(por), .bor_active_i(bor), .ext_reset_pin_n_i(pin_n),
		.sw_reset_i(sw), .wdog_timeout_i(wdt), .trap_conflict_i(trap), .illegal_cond_i(ill),
		.enter_sleep_i(slp), .enter_idle_i(idl), .wdog_fuse_enable_i(fuse), .initial_osc_select_i(osc_sel),
		.powerup_delay_sel_i(pdsel), .clock_fail_monitor_en_i(mon_en), .osc_tick_i(tick), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .master_reset_n_o(mrst_n),
		.current_osc_select_o(cur_osc), .osc_enable_o(osc_en), .clock_ready_o(ready), .fetch_addr_o(fetch),
		.monitor_active_o(mon), .wdog_enable_o(wden), .regulator_sleep_keep_o(keep), .wdog_wake_o(wake));
	core_model core_model_inst (.master_reset_n_i(mrst_n), .go_i(go), .cmd_i(cmd), .sw_reset_o(sw),
		.trap_conflict_o(trap), .illegal_cond_o(ill), .wdog_timeout_o(wdt), .enter_sleep_o(slp), .enter_idle_o(idl));

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Register write: one cycle with the strobe high.
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Register read: data stands only in the cycle after the strobe, so it is sampled there.
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic ev(input logic [2:0] k);
		@(posedge clk);
		cmd <= k;
		go  <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	// Bounded wait for the core to leave reset; a hang counts as a mismatch.
	task automatic wait_run;
		n = 0;
		repeat (5) @(posedge clk);
		while (mrst_n !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
			failures++;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Slow oscillator level, wake counter and run-time ceiling.
	always @(posedge clk) begin
		cyc++;
		tick <= cyc[2];
		if (wake === 1'b1)
			wakes++;
		if (cyc == 20000) begin
			failures++;
			complete_run;
		end
	end

	initial begin
		{rst_b, bor, fuse, tick, go, wr, rd, cmd, addr, wdata} = '0;
		{por, pin_n} = 2'b11;
		osc_sel = OSC_FRC;
		pdsel = 3'h0;
		mon_en = 1'b1;
		void'($urandom(9));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		por <= 1'b0;
		wait_run;
		rd_chk(ADDR_CAUSE, 16'h0001);
		chk({13'h0, cur_osc}, {13'h0, OSC_FRC});
		// The monitor needs its own start delay after clock ready before it is seen active.
		repeat (8) @(posedge clk);
		chk({12'h0, ready, osc_en, mon, fetch == 24'h000000}, 16'h000F);
		for (int i = 0; i < 3; i++) begin
			d = 16'($urandom);
			exp = d & CAUSE_MASK;
			wr_reg(ADDR_CAUSE, d);
			rd_chk(ADDR_CAUSE, exp[15:0]);
			chk({14'h0, keep, wden}, {14'h0, exp[8], exp[5]});
			chk({15'h0, mrst_n}, 16'h0001);
		end
		rd_chk(4'hF, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			wr_reg(ADDR_CAUSE, 16'h0000);
			ev(3'(k));
			wait_run;
			exp = 1 << bits[k];
			rd_chk(ADDR_CAUSE, exp[15:0]);
			chk({13'h0, cur_osc}, {13'h0, OSC_FRC});
		end
		wr_reg(ADDR_CAUSE, 16'h0000);
		pin_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk({15'h0, mrst_n}, 16'h0000);
		pin_n <= 1'b1;
		wait_run;
		rd_chk(ADDR_CAUSE, 16'h0080);
		wr_reg(ADDR_CAUSE, 16'h0000);
		ev(3'h5);
		ev(3'h4);
		rd_chk(ADDR_CAUSE, 16'h000C);
		ev(3'h3);
		repeat (4) @(posedge clk);
		chk(16'(wakes), 16'h0001);
		chk({15'h0, mrst_n}, 16'h0001);
		fuse <= 1'b1;
		wr_reg(ADDR_CAUSE, 16'h0000);
		repeat (2) @(posedge clk);
		chk({15'h0, wden}, 16'h0001);
		osc_sel <= OSC_EC;
		pdsel <= 3'h1;
		mon_en <= 1'b0;
		bor <= 1'b1;
		repeat (20) @(posedge clk);
		chk({15'h0, mrst_n}, 16'h0000);
		bor <= 1'b0;
		wait_run;
		rd_chk(ADDR_CAUSE, 16'h0002);
		chk({13'h0, cur_osc}, {13'h0, OSC_EC});
		repeat (8) @(posedge clk);
		chk({15'h0, mon}, 16'h0000);
		complete_run;
	end
endmodule
